// ==== hw/scw_pkg.sv ====
package scw_pkg;
   // ****************************************************************
   // Word addresses and layouts
   // ****************************************************************
   localparam logic [4:0] SCW_ADDR_SETUP = 5'h02;
   localparam logic [4:0] SCW_ADDR_CAP = 5'h06;
   localparam logic [4:0] SCW_ADDR_TEMP = 5'h11;
   localparam logic [15:0] SCW_SETUP_RESET = 16'h0B00;
   localparam logic [15:0] SCW_CAP_RESET = 16'h0C06;
   localparam logic [15:0] SCW_TEMP_RESET = 16'h8D92;
   localparam int SCW_MEMLOCK_LSB = 5;
   localparam int SCW_ADRLOCK_LSB = 8;
   localparam int SCW_OUTSEL_LSB = 11;
   localparam int SCW_ALGO_BIT = 14;
   localparam int SCW_RES_LSB = 10;
   localparam int SCW_DIFF_BIT = 14;
   localparam logic [2:0] SCW_LOCK_CODE = 3'h3;
   localparam logic [2:0] SCW_OUT_I2C = 3'h1;
   localparam logic [2:0] SCW_OUT_SPI = 3'h3;
   localparam logic [2:0] SCW_OUT_PDM_C = 3'h4;
   localparam logic [2:0] SCW_OUT_PDM_CT = 3'h6;
   // ****************************************************************
   // Conversion times, typical in microseconds, worst case x1.1
   // ****************************************************************
   localparam int SCW_CLK_MHZ = 100;
   localparam int SCW_T8_US = 700;
   localparam int SCW_T10_US = 1600;
   localparam int SCW_T12_US = 5000;
   localparam int SCW_T14_US = 18500;
   localparam int SCW_WORST_NUM = 11;
   localparam int SCW_WORST_DEN = 10;
   localparam int SCW_CYC8 = SCW_T8_US * SCW_CLK_MHZ;
   localparam int SCW_CYC10 = SCW_T10_US * SCW_CLK_MHZ;
   localparam int SCW_CYC12 = SCW_T12_US * SCW_CLK_MHZ;
   localparam int SCW_CYC14 = SCW_T14_US * SCW_CLK_MHZ;
   typedef enum logic [1:0] {SCW_IDLE = 2'b00, SCW_LOAD = 2'b01, SCW_CONV = 2'b11} scw_state_t;
endpackage

// ==== hw/scw_conv_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module scw_conv_timer
   import scw_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic start,
   input wire logic [1:0] resCode,
   input wire logic worstCase,
   output logic done
);
   logic [31:0] count;
   logic [31:0] next_count;
   logic next_done;

   // Typical or worst-case cycle budget for a resolution code
   function automatic logic [31:0] scw_budget(input logic [1:0] code, input logic worst);
      logic [31:0] typ;
      typ = 32'h0;
      unique case (code)
         2'b00: typ = 32'(SCW_CYC8);
         2'b01: typ = 32'(SCW_CYC10);
         2'b10: typ = 32'(SCW_CYC12);
         2'b11: typ = 32'(SCW_CYC14);
      endcase
      return worst ? 32'((typ * SCW_WORST_NUM) / SCW_WORST_DEN) : typ;
   endfunction

   always_comb
   begin
      next_count = count;
      next_done = 1'b0;
      if (start)
         next_count = scw_budget(resCode, worstCase);
      else if (count == 32'h1)
      begin
         next_count = 32'h0;
         next_done = 1'b1;
      end
      else if (count != 32'h0)
         next_count = count - 32'h1;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         count <= 32'h0;
         done <= 1'b0;
      end
      else
      begin
         count <= next_count;
         done <= next_done;
      end
   end

   chk_worst_budget: assert property (@(posedge mclk) disable iff (reset)
      start && worstCase && resCode == 2'b00 |=> count == 32'((SCW_CYC8 * 11) / 10))
      else $error("worst-case budget wrong");
endmodule // scw_conv_timer
`default_nettype wire

// ==== hw/sensor_config_words.sv ====
// Contract
// - Memory lock code stops pump and programming
// - Address lock field bits 10:8, default locked
// - Unlocked address lock answers every address
// - Output select codes I2C SPI two PDM
// - Setup bit 14 picks correction algorithm
// - Reload front-end words before each measurement
// - Cap reference 2:0 and offset 5:3
// - Cap resolution 11:10 sets width, time
// - Worst-case times are typical times 1.1
// - Cap bit 14 selects differential input
// - Temperature resolution uses same encoding
// - Setup latched at reset and leave-command
`timescale 1ns/1ns
`default_nettype none
module sensor_config_words
   import scw_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic cmdMode,
   input wire logic leave_command_mode_cmd,
   input wire logic wrEn,
   input wire logic [4:0] wrAddr,
   input wire logic [15:0] wrData,
   input wire logic [4:0] rdAddr,
   input wire logic measReq,
   input wire logic worstCase,
   input wire logic [6:0] ownAddr,
   input wire logic [6:0] busAddr,
   output logic [15:0] rdData,
   output logic progEnable,
   output logic pumpEnable,
   output logic addrMatch,
   output logic [2:0] outSelect,
   output logic outSelectBad,
   output logic thirdOrder,
   output logic [2:0] ref_cap_select,
   output logic [2:0] offset_cap_select,
   output logic [1:0] capRes,
   output logic differential,
   output logic [2:0] tempRefCap,
   output logic [2:0] tempOffsetCap,
   output logic [2:0] tempTrim,
   output logic [1:0] tempRes,
   output logic measBusy,
   output logic measDone
);
   // ****************************************************************
   // Stored words and active copies
   // ****************************************************************
   logic [15:0] setupStore, capStore, tempStore;
   logic [15:0] next_setupStore, next_capStore, next_tempStore;
   logic [15:0] setupAct, next_setupAct;
   logic [15:0] capAct, tempAct, next_capAct, next_tempAct;
   logic [15:0] next_rdData;
   logic next_progEnable, next_addrMatch, next_outSelectBad;
   logic memLocked;
   scw_state_t state, next_state;
   logic timerStart, timerDone;

   function automatic logic scw_out_legal(input logic [2:0] code);
      return code == SCW_OUT_I2C || code == SCW_OUT_SPI ||
             code == SCW_OUT_PDM_C || code == SCW_OUT_PDM_CT;
   endfunction

   // Lock decision comes from the latched setup, not the pending store
   assign memLocked = setupAct[SCW_MEMLOCK_LSB +: 3] == SCW_LOCK_CODE;

   always_comb
   begin
      next_setupStore = setupStore;
      next_capStore = capStore;
      next_tempStore = tempStore;
      // Writes only in command mode and while programming is open
      if (wrEn && cmdMode && !memLocked)
      begin
         unique case (wrAddr)
            SCW_ADDR_SETUP: next_setupStore = wrData;
            SCW_ADDR_CAP: next_capStore = wrData;
            SCW_ADDR_TEMP: next_tempStore = wrData;
            default: ;
         endcase
      end
      next_rdData = 16'h0000;
      unique case (rdAddr)
         SCW_ADDR_SETUP: next_rdData = setupStore;
         SCW_ADDR_CAP: next_rdData = capStore;
         SCW_ADDR_TEMP: next_rdData = tempStore;
         default: next_rdData = 16'h0000;
      endcase
   end

   always_comb
   begin
      next_setupAct = setupAct;
      if (leave_command_mode_cmd)
         next_setupAct = setupStore;
      next_progEnable = !memLocked;
      // Address match gated by the address lock field
      if (setupAct[SCW_ADRLOCK_LSB +: 3] == SCW_LOCK_CODE)
         next_addrMatch = busAddr == ownAddr;
      else
         next_addrMatch = 1'b1;
      next_outSelectBad = !scw_out_legal(setupAct[SCW_OUTSEL_LSB +: 3]);
   end

   // ****************************************************************
   // Measurement sequencer
   // ****************************************************************
   always_comb
   begin
      next_state = state;
      next_capAct = capAct;
      next_tempAct = tempAct;
      timerStart = 1'b0;
      unique case (state)
         SCW_IDLE:
            if (measReq)
               next_state = SCW_LOAD;
         SCW_LOAD:
         begin
            next_capAct = capStore;
            next_tempAct = tempStore;
            timerStart = 1'b1;
            next_state = SCW_CONV;
         end
         SCW_CONV:
            if (timerDone)
               next_state = SCW_IDLE;
         default: next_state = SCW_IDLE;
      endcase
   end

   scw_conv_timer u_timer (
      .mclk(mclk),
      .reset(reset),
      .start(timerStart),
      .resCode(capStore[SCW_RES_LSB +: 2]),
      .worstCase(worstCase),
      .done(timerDone)
   );

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         setupStore <= SCW_SETUP_RESET;
         capStore <= SCW_CAP_RESET;
         tempStore <= SCW_TEMP_RESET;
         setupAct <= SCW_SETUP_RESET;
         capAct <= SCW_CAP_RESET;
         tempAct <= SCW_TEMP_RESET;
         rdData <= 16'h0000;
         progEnable <= 1'b1;
         pumpEnable <= 1'b1;
         addrMatch <= 1'b0;
         outSelectBad <= 1'b0;
         state <= SCW_IDLE;
         measBusy <= 1'b0;
         measDone <= 1'b0;
      end
      else
      begin
         setupStore <= next_setupStore;
         capStore <= next_capStore;
         tempStore <= next_tempStore;
         setupAct <= next_setupAct;
         capAct <= next_capAct;
         tempAct <= next_tempAct;
         rdData <= next_rdData;
         progEnable <= next_progEnable;
         pumpEnable <= next_progEnable;
         addrMatch <= next_addrMatch;
         outSelectBad <= next_outSelectBad;
         state <= next_state;
         measBusy <= next_state != SCW_IDLE;
         measDone <= state == SCW_CONV && timerDone;
      end
   end

   // ****************************************************************
   // Field outputs from registered words
   // ****************************************************************
   always_comb
   begin
      outSelect = setupAct[SCW_OUTSEL_LSB +: 3];
      thirdOrder = setupAct[SCW_ALGO_BIT];
      ref_cap_select = capAct[2:0];
      offset_cap_select = capAct[5:3];
      capRes = capAct[SCW_RES_LSB +: 2];
      differential = capAct[SCW_DIFF_BIT];
      tempRefCap = tempAct[2:0];
      tempOffsetCap = tempAct[5:3];
      tempTrim = tempAct[8:6];
      tempRes = tempAct[SCW_RES_LSB +: 2];
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_mem_lock: assert property (@(posedge mclk) disable iff (reset)
      memLocked |=> !progEnable && !pumpEnable) else $error("lock not honoured");
   chk_lock_write: assert property (@(posedge mclk) disable iff (reset)
      memLocked && wrEn && wrAddr == SCW_ADDR_CAP |=> $stable(capStore))
      else $error("write while locked");
   chk_addr_locked: assert property (@(posedge mclk) disable iff (reset)
      setupAct[10:8] == SCW_LOCK_CODE && busAddr != ownAddr |=> !addrMatch)
      else $error("foreign address accepted");
   chk_addr_open: assert property (@(posedge mclk) disable iff (reset)
      setupAct[10:8] != SCW_LOCK_CODE |=> addrMatch) else $error("address refused");
   chk_out_legal: assert property (@(posedge mclk) disable iff (reset)
      setupAct[13:11] == 3'h2 |=> outSelectBad) else $error("bad code not flagged");
   chk_reload_meas: assert property (@(posedge mclk) disable iff (reset)
      state == SCW_LOAD |=> capAct == $past(capStore) && tempAct == $past(tempStore))
      else $error("no reload");
   chk_setup_latch: assert property (@(posedge mclk) disable iff (reset)
      leave_command_mode_cmd |=> setupAct == $past(setupStore))
      else $error("setup not latched");
   chk_meas_done: assert property (@(posedge mclk) disable iff (reset)
      state == SCW_LOAD |=> state == SCW_CONV ##1 !measDone)
      else $error("measure ended early");
endmodule // sensor_config_words
`default_nettype wire

// ==== bench/scw_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module scw_host
   import scw_pkg::*;
(
   input wire logic mclk,
   output logic wrEn,
   output logic [4:0] wrAddr,
   output logic [15:0] wrData
);
   initial
   begin
      wrEn = 1'b0;
      wrAddr = 5'h00;
      wrData = 16'h0000;
   end
   // ****************************************
   // Host write cycle, legal words only
   // ****************************************
   task automatic write_word(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] w;
      w = d & 16'h7FFF;
      if (a == SCW_ADDR_CAP)
         w = d & 16'h4C3F;
      if (a == SCW_ADDR_TEMP)
         w = (d & 16'h0C00) | 16'h8192;
      if (a == SCW_ADDR_SETUP && !(w[13:11] inside {3'h1, 3'h3, 3'h4, 3'h6}))
         w[13:11] = SCW_OUT_I2C;
      @(negedge mclk);
      wrEn = 1'b1;
      wrAddr = a;
      wrData = w;
      @(negedge mclk);
      wrEn = 1'b0;
      // Released lines must not keep the old word
      wrAddr = ~a;
      wrData = ~w;
   endtask
endmodule // scw_host
`default_nettype wire

// ==== bench/sensor_config_words_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module sensor_config_words_test
   import scw_pkg::*;
;
   logic mclk, reset, cmdMode, leaveCmd, wrEn, measReq, worstCase;
   logic [4:0] wrAddr, rdAddr;
   logic [15:0] wrData, rdData, mSetup, mCap, mTemp, aSetup, c;
   logic [6:0] ownAddr, busAddr;
   logic progEnable, pumpEnable, addrMatch, outSelectBad, thirdOrder, differential;
   logic measBusy, measDone;
   logic [2:0] outSelect, refCap, offCap, tempRefCap, tempOffsetCap, tempTrim;
   logic [1:0] capRes, tempRes;
   int fails = 0, samples_checked = 0, seed = 47507, i, n;
   logic [2:0] codes [4] = '{3'h1, 3'h3, 3'h4, 3'h6};
   sensor_config_words sensor_config_words_inst (.mclk(mclk), .reset(reset),
      .cmdMode(cmdMode), .leave_command_mode_cmd(leaveCmd), .wrEn(wrEn), .wrAddr(wrAddr),
      .wrData(wrData), .rdAddr(rdAddr), .measReq(measReq), .worstCase(worstCase),
      .ownAddr(ownAddr), .busAddr(busAddr), .rdData(rdData), .progEnable(progEnable),
      .pumpEnable(pumpEnable), .addrMatch(addrMatch), .outSelect(outSelect),
      .outSelectBad(outSelectBad), .thirdOrder(thirdOrder), .ref_cap_select(refCap),
      .offset_cap_select(offCap), .capRes(capRes), .differential(differential),
      .tempRefCap(tempRefCap), .tempOffsetCap(tempOffsetCap), .tempTrim(tempTrim),
      .tempRes(tempRes), .measBusy(measBusy), .measDone(measDone));
   scw_host scw_host_inst (.mclk(mclk), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData));
   // ****************************************
   // Checking tasks and reference model
   // ****************************************
   task automatic wrap_up();
      if (fails == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      rdAddr = a;
      @(negedge mclk);
      chk(rdData, exp);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      scw_host_inst.write_word(a, d);
      if (cmdMode && aSetup[7:5] != 3'h3)
         case (a)
            SCW_ADDR_SETUP: mSetup = d;
            SCW_ADDR_CAP: mCap = d;
            SCW_ADDR_TEMP: mTemp = d;
            default: ;
         endcase
   endtask
   task automatic leave();
      leaveCmd = 1'b1;
      @(negedge mclk);
      leaveCmd = 1'b0;
      repeat (2) @(negedge mclk);
      aSetup = mSetup;
   endtask
   task automatic chkSetup();
      logic lk;
      lk = aSetup[7:5] != 3'h3;
      chk({11'h0, outSelect, thirdOrder, progEnable}, {11'h0, aSetup[13:11], aSetup[14], lk});
      chk({14'h0, pumpEnable, outSelectBad}, {14'h0, lk, 1'b0});
   endtask
   task automatic chkFe(input logic [15:0] cw, input logic [15:0] tw);
      chk({7'h0, differential, capRes, offCap, refCap}, {7'h0, cw[14], cw[11:10], cw[5:0]});
      chk({5'h0, tempRes, tempTrim, tempOffsetCap, tempRefCap}, {5'h0, tw[11:10], tw[8:0]});
   endtask
   task automatic addrChk();
      for (i = 0; i < 6; i++)
      begin
         ownAddr = 7'($random(seed));
         busAddr = i[0] ? ownAddr : 7'($random(seed));
         repeat (2) @(negedge mclk);
         chk({15'h0, addrMatch}, {15'h0, aSetup[10:8] != 3'h3 || busAddr == ownAddr});
      end
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      repeat (90000) @(posedge mclk);
      fails++;
      wrap_up();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      {reset, cmdMode, leaveCmd, measReq, worstCase} = 5'b11000;
      {rdAddr, ownAddr, busAddr} = 19'h0;
      {mSetup, mCap, mTemp} = {16'h0B00, 16'h0C06, 16'h8D92};
      aSetup = mSetup;
      repeat (3) @(negedge mclk);
      reset = 1'b0;
      rd(SCW_ADDR_SETUP, mSetup);
      rd(SCW_ADDR_CAP, mCap);
      rd(SCW_ADDR_TEMP, mTemp);
      rd(5'h1F, 16'h0000);
      chkSetup();
      chkFe(mCap, mTemp);
      addrChk();
      cmdMode = 1'b0;
      wr(SCW_ADDR_CAP, 16'h4C3F);
      cmdMode = 1'b1;
      rd(SCW_ADDR_CAP, mCap);
      for (n = 0; n < 4; n++)
      begin
         wr(SCW_ADDR_SETUP, {1'b0, n[0], codes[n], (n == 3) ? 3'h3 : n[2:0], 8'h00});
         chkSetup();
         leave();
         chkSetup();
         addrChk();
      end
      c = {2'b01, 4'h0, 4'h0, 6'($random(seed))};
      wr(SCW_ADDR_CAP, c);
      wr(SCW_ADDR_TEMP, 16'h8592);
      chkFe(16'h0C06, 16'h8D92);
      // 8-bit resolution keeps the run short; the worst-case budget adds a tenth
      worstCase = 1'b1;
      measReq = 1'b1;
      @(negedge mclk);
      measReq = 1'b0;
      for (n = 1; n < 80000 && !measDone; n++)
         @(negedge mclk);
      chk({15'h0, n >= (SCW_CYC8 * 11) / 10 && n <= (SCW_CYC8 * 11) / 10 + 4}, 16'h0001);
      chkFe(mCap, mTemp);
      @(negedge mclk);
      chk({15'h0, measBusy}, 16'h0000);
      wr(SCW_ADDR_SETUP, 16'h0B60);
      leave();
      chkSetup();
      wr(SCW_ADDR_CAP, 16'h0C06);
      rd(SCW_ADDR_CAP, mCap);
      wrap_up();
   end
endmodule // sensor_config_words_test
`default_nettype wire
